// >>> hw/iafs_fifo.sv
`timescale 1ns/1ps
// synchronous fifo, flop storage indexed by pointers, show-ahead read
module iafs_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH]; // storage words
	logic [AW-1:0] wr_ptr_q; // next slot to write
	logic [AW-1:0] rd_ptr_q; // oldest word
	logic [AW:0] count_q; // words held, one bit wider than pointers
	logic push; // accepted write
	logic pop; // accepted read

	// full and empty straight from the occupancy count
	assign in_ready = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data = mem_q[rd_ptr_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage write, no reset needed on data
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// pointers wrap naturally since depth is a power of two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
		end
	end

	// occupancy, simultaneous push and pop leave it unchanged
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= '0;
		end else if (push && !pop) begin
			count_q <= count_q + 1'b1;
		end else if (pop && !push) begin
			count_q <= count_q - 1'b1;
		end
	end
endmodule : iafs_fifo

// >>> hw/iafs_converter.sv
// Operation
// - conversion ends, acquisition follows by itself
// - chip-select fall starts the conversion phase
// - 24 clocks in a frame enter trim
// - trim keeps sampling capacitors off both inputs
// - trimmed offset applies until power loss
package iafs_pkg;
	localparam int DATA_W = 14; // result width
	localparam int FIFO_DEPTH = 16; // words buffered toward the system side
	localparam int CNT_W = 5; // serial edge counter width
	localparam int SYNC_STAGES = 3; // synchroniser depth for foreign inputs
	localparam int SCLK_PERIOD_PS = 16670; // nominal serial clock period
	localparam int ACQ_MIN_PS = 95000; // least acquisition time
	localparam int ACQ_MIN_CYCLES = (ACQ_MIN_PS + SCLK_PERIOD_PS - 1) / SCLK_PERIOD_PS; // rounds up to six
	localparam logic [CNT_W-1:0] CONV_EDGES = 5'h12; // edges of the conversion phase
	localparam logic [CNT_W-1:0] CAL_EDGES = 5'h18; // edges that turn a frame into a trim frame
	localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f; // counter saturation
	localparam logic [DATA_W-1:0] OFFSET_RST = 14'h0000; // offset before any trim
	// frame states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_CONV = 4'b0010,
		ST_ACQ = 4'b0100,
		ST_TRIM = 4'b1000
	} iafs_state_t;
endpackage : iafs_pkg

`timescale 1ns/1ps
// converter digital core: frame sequencing, offset trim, result stream
module iafs_converter (
	// system clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// serial link from the host
	input wire logic sclk,
	input wire logic cs_n,
	output logic sdo,
	// comparator array codes, stable while sampled in the serial domain
	input wire logic [iafs_pkg::DATA_W-1:0] conv_code,
	input wire logic [iafs_pkg::DATA_W-1:0] cal_code,
	// analog phase controls
	output logic conversion_phase,
	output logic sample_window_phase,
	output logic offset_trim_state,
	// result stream on the system clock
	output logic out_valid,
	input wire logic out_ready,
	output logic [iafs_pkg::DATA_W-1:0] out_data,
	// status on the system clock
	output logic offset_trimmed,
	output logic overrun
);
	import iafs_pkg::*;

	// saturating offset removal, negative results clamp at zero
	function automatic logic [DATA_W-1:0] remove_offset(input logic [DATA_W-1:0] raw,
			input logic [DATA_W-1:0] off);
		logic [DATA_W:0] diff;
		diff = {1'b0, raw} - {1'b0, off};
		return diff[DATA_W] ? '0 : diff[DATA_W-1:0];
	endfunction : remove_offset

	// edge counter decode, used by several processes
	function automatic logic at_edge(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] n);
		return cnt == (n - 5'h01);
	endfunction : at_edge

	// serial domain state
	iafs_state_t state_q; // frame state
	iafs_state_t state_d; // next frame state
	logic [CNT_W-1:0] cnt_q; // sclk edges seen in this frame
	logic conv_hold_q; // conversion phase, set by chip-select fall
	logic acq_q; // acquisition, switch closed
	logic trim_q; // offset trim active
	logic acq_clr_q; // end of conversion, releases conv_hold_q
	logic hold_clr_n; // async clear for conv_hold_q
	logic sdo_q; // serial data bit
	logic [DATA_W-1:0] offset_q; // trimmed offset, kept until reset
	logic [DATA_W-1:0] result_q; // last corrected result
	logic res_tgl_q; // flips once per new result
	logic cal_done_q; // a trim has been taken

	// system domain state
	logic [SYNC_STAGES-1:0] tgl_sync_q; // result toggle synchroniser
	logic [SYNC_STAGES-1:0] cal_sync_q; // trim done synchroniser
	logic tgl_seen_q; // last accepted toggle level
	logic new_result; // a result crossed over
	logic fifo_in_ready; // fifo has room
	logic fifo_out_valid; // fifo holds a word
	logic fifo_pop; // move a word into the output stage
	logic [DATA_W-1:0] fifo_out_data; // head word
	logic out_valid_q; // output stage full
	logic [DATA_W-1:0] out_data_q; // output stage word
	logic trimmed_q; // trim seen on the system side
	logic overrun_q; // sticky, result lost on a full fifo

	// conversion phase starts at the chip-select fall itself, not at the
	// first serial edge, so the sampling instant is the select edge
	assign hold_clr_n = rst_n & ~acq_clr_q;
	always_ff @(negedge cs_n or negedge hold_clr_n) begin
		if (!hold_clr_n) begin
			conv_hold_q <= 1'b0;
		end else begin
			conv_hold_q <= 1'b1;
		end
	end

	// frame state advance; a raised select ends the frame without a clock
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				state_d = ST_CONV;
			end
			ST_CONV: begin
				if (at_edge(cnt_q, CONV_EDGES)) begin
					state_d = ST_ACQ;
				end
			end
			ST_ACQ: begin
				if (at_edge(cnt_q, CAL_EDGES)) begin
					state_d = ST_TRIM;
				end
			end
			ST_TRIM: begin
				state_d = ST_TRIM;
			end
		endcase
	end

	// state register, reset by the frame's own select
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// edge counter, saturates so very long frames stay in trim
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			cnt_q <= '0;
		end else if (cnt_q != CNT_MAX) begin
			cnt_q <= cnt_q + 5'h01;
		end
	end

	// acquisition flag; between frames the input tracks, so it idles high
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			acq_q <= 1'b1;
		end else if (state_q == ST_IDLE) begin
			acq_q <= 1'b0; // conversion holds the sample
		end else if (state_q == ST_CONV && at_edge(cnt_q, CONV_EDGES)) begin
			acq_q <= 1'b1;
		end else if (state_q == ST_ACQ && at_edge(cnt_q, CAL_EDGES)) begin
			acq_q <= 1'b0;
		end
	end

	// end-of-conversion marker, clears the select-edge hold flop
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			acq_clr_q <= 1'b0;
		end else if (state_q == ST_CONV && at_edge(cnt_q, CONV_EDGES)) begin
			acq_clr_q <= 1'b1;
		end
	end

	// trim flag, capacitors stay off both inputs until the select rises
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			trim_q <= 1'b0;
		end else if (state_q == ST_ACQ && at_edge(cnt_q, CAL_EDGES)) begin
			trim_q <= 1'b1;
		end
	end

	// offset register; only a power-on reset forgets it
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			offset_q <= OFFSET_RST;
			cal_done_q <= 1'b0;
		end else if (!cs_n && state_q == ST_ACQ && at_edge(cnt_q, CAL_EDGES)) begin
			offset_q <= cal_code;
			cal_done_q <= 1'b1;
		end
	end

	// result capture with the trimmed offset removed, then toggle the event
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			result_q <= '0;
			res_tgl_q <= 1'b0;
		end else if (!cs_n && state_q == ST_CONV && at_edge(cnt_q, CONV_EDGES)) begin
			result_q <= remove_offset(conv_code, offset_q);
			res_tgl_q <= ~res_tgl_q;
		end
	end

	// previous result shifted out msb first on edges one to fourteen
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			sdo_q <= 1'b0;
		end else if (cnt_q < 5'(DATA_W)) begin
			sdo_q <= result_q[DATA_W-1 - int'(cnt_q)];
		end else begin
			sdo_q <= 1'b0;
		end
	end

	assign sdo = sdo_q;
	assign conversion_phase = conv_hold_q;
	assign sample_window_phase = acq_q;
	assign offset_trim_state = trim_q;

	// toggle synchroniser; first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tgl_sync_q <= '0;
			cal_sync_q <= '0;
		end else begin
			tgl_sync_q <= {tgl_sync_q[SYNC_STAGES-2:0], res_tgl_q};
			cal_sync_q <= {cal_sync_q[SYNC_STAGES-2:0], cal_done_q};
		end
	end

	// a toggle counts once the last two stages agree on a new level;
	// the result word has been stable for several system clocks by then
	assign new_result = (tgl_sync_q[2] == tgl_sync_q[1]) && (tgl_sync_q[2] != tgl_seen_q);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tgl_seen_q <= 1'b0;
		end else if (new_result) begin
			tgl_seen_q <= tgl_sync_q[2];
		end
	end

	// trim status, settled level only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trimmed_q <= 1'b0;
		end else if (cal_sync_q[2] == cal_sync_q[1]) begin
			trimmed_q <= cal_sync_q[2];
		end
	end

	// the converter cannot be stalled, so a full fifo drops the word
	// and leaves a sticky mark; only reset clears it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			overrun_q <= 1'b0;
		end else if (new_result && !fifo_in_ready) begin
			overrun_q <= 1'b1;
		end
	end

	// result buffer between the crossing and the consumer
	iafs_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(new_result),
		.in_ready(fifo_in_ready),
		.in_data(result_q),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	// registered output stage so the stream pins come from flops
	assign fifo_pop = fifo_out_valid && (!out_valid_q || out_ready);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid_q <= 1'b0;
			out_data_q <= '0;
		end else if (fifo_pop) begin
			out_valid_q <= 1'b1;
			out_data_q <= fifo_out_data;
		end else if (out_ready) begin
			out_valid_q <= 1'b0;
		end
	end

	assign out_valid = out_valid_q;
	assign out_data = out_data_q;
	assign offset_trimmed = trimmed_q;
	assign overrun = overrun_q;
endmodule : iafs_converter

// >>> verif/iafs_converter_sva.sv
`timescale 1ns/1ps
// watches frame phases on the link and the result stream on the system clock
module iafs_converter_chk (
	// clocks and reset
	input wire logic clk,
	input wire logic rst_n,
	// serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdo,
	// codes and phases
	input wire logic [iafs_pkg::DATA_W-1:0] conv_code,
	input wire logic [iafs_pkg::DATA_W-1:0] cal_code,
	input wire logic conversion_phase,
	input wire logic sample_window_phase,
	input wire logic offset_trim_state,
	// stream and status
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [iafs_pkg::DATA_W-1:0] out_data,
	input wire logic offset_trimmed,
	input wire logic overrun
);
	import iafs_pkg::*;
	logic [CNT_W-1:0] cnt_q; // edges seen in this frame
	// edge count, cleared while select is high, saturating
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			cnt_q <= '0;
		end else if (cnt_q != CNT_MAX) begin
			cnt_q <= cnt_q + 5'h01;
		end
	end
	// link phases, judged only inside a frame
	conv_hold_a: assert property (@(posedge sclk) disable iff (cs_n || !rst_n)
		cnt_q < CONV_EDGES |-> conversion_phase) else $error("conversion ended early");
	acq_off_a: assert property (@(posedge sclk) disable iff (cs_n || !rst_n)
		cnt_q inside {[1:17]} |-> !sample_window_phase) else $error("switch closed in conversion");
	acq_auto_a: assert property (@(posedge sclk) disable iff (cs_n || !rst_n)
		cnt_q inside {[18:23]} |-> sample_window_phase && !conversion_phase) else $error("no acquisition");
	trim_enter_a: assert property (@(posedge sclk) disable iff (cs_n || !rst_n)
		cnt_q >= CAL_EDGES |-> offset_trim_state && !sample_window_phase) else $error("trim not entered");
	no_trim_a: assert property (@(posedge sclk) disable iff (cs_n || !rst_n)
		cnt_q < CAL_EDGES |-> !offset_trim_state) else $error("trim too early");
	// idle link seen from the system clock
	idle_state_a: assert property (@(posedge clk) disable iff (!rst_n)
		cs_n [*2] |-> sample_window_phase && !offset_trim_state) else $error("idle phase wrong");
	// stream holds until taken, trim kept until reset
	out_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("word not held");
	trim_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		offset_trimmed |=> offset_trimmed) else $error("trim forgotten");
	cover property (@(posedge sclk) offset_trim_state);
	cover property (@(posedge clk) out_valid && out_ready);
	cover property (@(posedge clk) overrun);
endmodule : iafs_converter_chk

bind iafs_converter iafs_converter_chk u_iafs_converter_chk (.clk(clk), .rst_n(rst_n), .sclk(sclk),
	.cs_n(cs_n), .sdo(sdo), .conv_code(conv_code), .cal_code(cal_code), .conversion_phase(conversion_phase),
	.sample_window_phase(sample_window_phase), .offset_trim_state(offset_trim_state), .out_valid(out_valid),
	.out_ready(out_ready), .out_data(out_data), .offset_trimmed(offset_trimmed), .overrun(overrun));

// >>> verif/iafs_host_model.sv
`timescale 1ns/1ps
// host side of the link; the serial clock stands low outside frames
module iafs_host_model #(
	parameter int IDX = 0 // converter index within the interleaved set
) (
	// link pins
	output logic sclk,
	output logic cs_n,
	input logic sdo
);
	logic [iafs_pkg::DATA_W-1:0] rx_word; // bits read on sdo in the last frame, msb first
	// select released after time zero so the frame flops see a real rising edge
	initial begin
		sclk = 1'b0;
		rx_word = '0;
		#1 cs_n = 1'b1;
	end
	// one frame of n rising edges, each followed by a falling edge;
	// converter IDX starts eight serial clocks per index after slot zero
	task automatic frame(input int n);
		#(7 + 384 * IDX) cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			#24 sclk = 1'b1;
			#24 sclk = 1'b0;
			// data bit settled since the rising edge, read on the falling one
			if (i < iafs_pkg::DATA_W) begin
				rx_word = {rx_word[iafs_pkg::DATA_W-2:0], sdo};
			end
		end
		#10 cs_n = 1'b1;
		#300;
	endtask : frame
endmodule : iafs_host_model

// >>> verif/tb_top.sv
`timescale 1ns/1ps
// single converter against the host model, stream judged word by word
module tb_top;
	import iafs_pkg::*;
	logic clk;
	logic rst_n;
	logic sclk;
	logic cs_n;
	logic out_ready;
	logic out_valid;
	logic [DATA_W-1:0] conv_code, cal_code, out_data;
	logic conversion_phase, sample_window_phase, offset_trim_state, offset_trimmed, overrun;
	logic sdo; // serial data toward the host model
	int mismatches = 0;
	int tests_run = 0;
	int cyc = 0;
	// system clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	iafs_converter u_iafs_converter (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdo(sdo),
		.conv_code(conv_code), .cal_code(cal_code), .conversion_phase(conversion_phase),
		.sample_window_phase(sample_window_phase), .offset_trim_state(offset_trim_state),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
		.offset_trimmed(offset_trimmed), .overrun(overrun));
	iafs_host_model u_iafs_host_model (.sclk(sclk), .cs_n(cs_n), .sdo(sdo));
	// verdict and end of run
	task automatic tally_and_finish();
		$display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	// hang guard, well above the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// code set off the clock edge, then one frame of n edges
	task automatic shot(input logic [DATA_W-1:0] code, input int n);
		@(posedge clk);
		#1 conv_code = code;
		u_iafs_host_model.frame(n);
	endtask : shot
	// bounded wait for a word, compare, take it
	task automatic pull(input logic [DATA_W-1:0] exp);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		while (out_valid !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(out_valid, 1'b1);
		chk(out_data, exp);
		out_ready = 1'b1;
		@(posedge clk);
		#1 out_ready = 1'b0;
	endtask : pull
	task automatic t_reset();
		chk(out_valid, 1'b0);
		chk(overrun, 1'b0);
		chk(offset_trimmed, 1'b0);
		chk(sample_window_phase, 1'b1);
		chk(offset_trim_state, 1'b0);
	endtask : t_reset
	// full frame gives a word, a short one gives none
	task automatic t_plain();
		shot(14'h1234, 18);
		pull(14'h1234);
		shot(14'h0abc, 17);
		chk(u_iafs_host_model.rx_word, 14'h1234);
		repeat (20) @(posedge clk);
		#1;
		chk(out_valid, 1'b0);
	endtask : t_plain
	// trim frame: old offset on its own word, new offset afterwards, clamp at zero
	task automatic t_trim();
		cal_code = 14'h0010;
		shot(14'h0100, 25);
		pull(14'h0100);
		chk(offset_trimmed, 1'b1);
		shot(14'h0105, 18);
		chk(u_iafs_host_model.rx_word, 14'h0100);
		pull(14'h00f5);
		shot(14'h0008, 18);
		pull(14'h0000);
	endtask : t_trim
	// consumer stalls until a word is lost, then drains in order
	task automatic t_fill();
		for (int i = 0; i < 18; i++) begin
			shot(14'h0020 + 14'(i), 18);
		end
		chk(overrun, 1'b1);
		for (int i = 0; i < 17; i++) begin
			pull(14'h0010 + 14'(i));
		end
		repeat (4) @(posedge clk);
		#1;
		chk(out_valid, 1'b0);
	endtask : t_fill
	// power loss forgets the offset, then a fresh trim at power-up
	task automatic t_power();
		@(posedge clk);
		#1 rst_n = 1'b0;
		repeat (6) @(posedge clk);
		#1 rst_n = 1'b1;
		chk(offset_trimmed, 1'b0);
		chk(overrun, 1'b0);
		cal_code = 14'h0004;
		shot(14'h0100, 24);
		pull(14'h0100);
		shot(14'h0100, 18);
		pull(14'h00fc);
	endtask : t_power
	// reset edge placed after time zero so every flop sees it
	initial begin
		out_ready = 1'b0;
		conv_code = '0;
		cal_code = '0;
		#1 rst_n = 1'b0;
		repeat (6) @(posedge clk);
		#1 rst_n = 1'b1;
		t_reset();
		t_plain();
		t_trim();
		t_fill();
		t_power();
		tally_and_finish();
	end
endmodule : tb_top
